// File: four_channel_pwm_servo_unit.sv
`timescale 1ns/1ps

// Function
// - After reset all four pulse outputs are low until software picks a mode.
// - Each pair runs in servo, duty cycle, universal or frequency mode.
// - Servo mode repeats every 20 ms with a high time from 1 ms to 2 ms.
// - Duty mode gives each channel its own duty and each pair one period.
// - Universal mode lets software set both period and duty of channel A.
// - Universal mode drives channel B at half the A frequency and 50% duty.
// - Frequency mode gives every channel its own frequency up to 20 kHz at 50% duty.
// - The wide pair takes right-justified 16-bit duty and period values.
// - The narrow pair takes right-justified 8-bit duty and period values.
// - Two analog output channels each take their own code when clk_en and that channel's strobe (ao_wr_0 or ao_wr_1) are both high.
// - Each analog code is a right-justified 10-bit value, 1023 being full scale.
module four_channel_pwm_servo_unit (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // pair settings
    input pwm_servo_pkg::pair_cfg_t wide_cfg,
    input pwm_servo_pkg::narrow_cfg_t narrow_cfg,
    // analog codes
    input wire logic [pwm_servo_pkg::AO_W-1:0] ao_code_0,
    input wire logic ao_wr_0,
    input wire logic [pwm_servo_pkg::AO_W-1:0] ao_code_1,
    input wire logic ao_wr_1,
    // pulse outputs
    output logic wide_pair_chan_a,
    output logic wide_pair_chan_b,
    output logic narrow_pair_chan_a,
    output logic narrow_pair_chan_b,
    // analog outputs
    output logic [pwm_servo_pkg::AO_W-1:0] analog_out_chan_0,
    output logic [pwm_servo_pkg::AO_W-1:0] analog_out_chan_1
);

    // ==========================================================
    // helpers
    // ==========================================================
    // servo high time in ticks from a setting
    function automatic logic [15:0] servo_high(input logic [15:0] set, input logic narrow);
        logic [15:0] scaled;
        scaled = narrow ? {set[13:0], 2'b00} : set;
        if (scaled > pwm_servo_pkg::SERVO_SPAN) begin
            scaled = pwm_servo_pkg::SERVO_SPAN;
        end
        return 16'(pwm_servo_pkg::SERVO_BASE + scaled);
    endfunction

    // half period in ticks, held above the 20 kHz limit
    function automatic logic [15:0] half_ticks(input logic [15:0] set);
        return (set < pwm_servo_pkg::HALF_MIN) ? pwm_servo_pkg::HALF_MIN : set;
    endfunction

    // ==========================================================
    // microsecond timebase
    // ==========================================================
    logic [15:0] us_cnt;
    logic us_tick;

    assign us_tick = (us_cnt == pwm_servo_pkg::TICK_LAST);

    // free running tick for servo and frequency modes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            us_cnt <= 16'h0000;
        end else if (clk_en) begin
            us_cnt <= us_tick ? 16'h0000 : 16'(us_cnt + 16'h0001);
        end
    end

    // ==========================================================
    // settings of both pairs at one width
    // ==========================================================
    pwm_servo_pkg::pair_cfg_t cfg_in [2];
    logic out_a [2];
    logic out_b [2];

    // narrow values are zero extended, keeping 8-bit resolution
    always_comb begin
        cfg_in[0] = wide_cfg;
        cfg_in[1].mode = narrow_cfg.mode;
        cfg_in[1].prescale = narrow_cfg.prescale;
        cfg_in[1].period = {8'h00, narrow_cfg.period};
        cfg_in[1].set_a = {8'h00, narrow_cfg.set_a};
        cfg_in[1].set_b = {8'h00, narrow_cfg.set_b};
    end

    // ==========================================================
    // pair engines
    // ==========================================================
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pair
            pwm_servo_pkg::pair_cfg_t sh;
            logic [15:0] pre_cnt;
            logic [15:0] cnt;
            logic [15:0] cnt_b;
            logic [15:0] top;
            logic [15:0] top_b;
            logic pre_tick;
            logic tick;
            logic wrap;
            logic wrap_b;
            logic load;
            logic tog_a;
            logic tog_b;
            logic next_out_a;
            logic next_out_b;
            logic is_narrow;

            assign is_narrow = (p == 1);
            assign pre_tick = (pre_cnt == sh.prescale);

            // timebase choice and count limits per mode
            always_comb begin
                tick = pre_tick;
                top = sh.period;
                top_b = 16'h0000;
                case (sh.mode)
                    pwm_servo_pkg::MODE_SERVO: begin
                        tick = us_tick;
                        top = pwm_servo_pkg::SERVO_TOP;
                    end
                    pwm_servo_pkg::MODE_FREQ: begin
                        tick = us_tick;
                        top = 16'(half_ticks(sh.set_a) - 16'h0001);
                        top_b = 16'(half_ticks(sh.set_b) - 16'h0001);
                    end
                    default: begin
                        tick = pre_tick;
                        top = sh.period;
                    end
                endcase
            end

            assign wrap = tick && (cnt >= top);
            assign wrap_b = tick && (cnt_b >= top_b);
            // settings taken only while idle or at a period boundary
            assign load = (sh.mode == pwm_servo_pkg::MODE_OFF) || wrap;

            // shadow copy of the settings
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    sh <= '0;
                    sh.mode <= pwm_servo_pkg::MODE_OFF;
                end else if (clk_en && load) begin
                    sh <= cfg_in[p];
                end
            end

            // prescaler for duty and universal modes
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    pre_cnt <= 16'h0000;
                end else if (clk_en) begin
                    if (sh.mode == pwm_servo_pkg::MODE_OFF || pre_tick) begin
                        pre_cnt <= 16'h0000;
                    end else begin
                        pre_cnt <= 16'(pre_cnt + 16'h0001);
                    end
                end
            end

            // main period counter
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    cnt <= 16'h0000;
                end else if (clk_en) begin
                    if (sh.mode == pwm_servo_pkg::MODE_OFF || wrap) begin
                        cnt <= 16'h0000;
                    end else if (tick) begin
                        cnt <= 16'(cnt + 16'h0001);
                    end
                end
            end

            // channel B half period counter for frequency mode
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    cnt_b <= 16'h0000;
                end else if (clk_en) begin
                    if (sh.mode != pwm_servo_pkg::MODE_FREQ || wrap_b) begin
                        cnt_b <= 16'h0000;
                    end else if (tick) begin
                        cnt_b <= 16'(cnt_b + 16'h0001);
                    end
                end
            end

            // toggle states for square wave outputs
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    tog_a <= 1'b0;
                    tog_b <= 1'b0;
                end else if (clk_en) begin
                    if (sh.mode == pwm_servo_pkg::MODE_FREQ) begin
                        if (wrap) begin
                            tog_a <= ~tog_a;
                        end
                        if (wrap_b) begin
                            tog_b <= ~tog_b;
                        end
                    end else if (sh.mode == pwm_servo_pkg::MODE_UNIVERSAL) begin
                        tog_a <= 1'b0;
                        if (wrap) begin
                            tog_b <= ~tog_b;
                        end
                    end else begin
                        tog_a <= 1'b0;
                        tog_b <= 1'b0;
                    end
                end
            end

            // output levels per mode
            always_comb begin
                next_out_a = 1'b0;
                next_out_b = 1'b0;
                case (sh.mode)
                    pwm_servo_pkg::MODE_SERVO: begin
                        next_out_a = cnt < servo_high(sh.set_a, is_narrow);
                        next_out_b = cnt < servo_high(sh.set_b, is_narrow);
                    end
                    pwm_servo_pkg::MODE_DUTY: begin
                        next_out_a = cnt < sh.set_a;
                        next_out_b = cnt < sh.set_b;
                    end
                    pwm_servo_pkg::MODE_UNIVERSAL: begin
                        next_out_a = cnt < sh.set_a;
                        next_out_b = tog_b;
                    end
                    pwm_servo_pkg::MODE_FREQ: begin
                        next_out_a = tog_a;
                        next_out_b = tog_b;
                    end
                    default: begin
                        next_out_a = 1'b0;
                        next_out_b = 1'b0;
                    end
                endcase
            end

            // registered pulse outputs
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    out_a[p] <= 1'b0;
                    out_b[p] <= 1'b0;
                end else if (clk_en) begin
                    out_a[p] <= next_out_a;
                    out_b[p] <= next_out_b;
                end
            end
        end
    endgenerate

    assign wide_pair_chan_a = out_a[0];
    assign wide_pair_chan_b = out_b[0];
    assign narrow_pair_chan_a = out_a[1];
    assign narrow_pair_chan_b = out_b[1];

    // ==========================================================
    // analog output codes
    // ==========================================================
    // each channel latches its own code on its own strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            analog_out_chan_0 <= pwm_servo_pkg::AO_RESET;
        end else if (clk_en && ao_wr_0) begin
            analog_out_chan_0 <= ao_code_0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            analog_out_chan_1 <= pwm_servo_pkg::AO_RESET;
        end else if (clk_en && ao_wr_1) begin
            analog_out_chan_1 <= ao_code_1;
        end
    end

endmodule // four_channel_pwm_servo_unit

// File: pwm_servo_pkg.sv
package pwm_servo_pkg;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = (TICK_US * 1000000) / CLK_PERIOD_PS;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    localparam int SERVO_PERIOD_US = 20000;
    localparam int SERVO_MIN_US = 1000;
    localparam int SERVO_MAX_US = 2000;
    localparam logic [15:0] SERVO_TOP = 16'(SERVO_PERIOD_US / TICK_US - 1);
    localparam logic [15:0] SERVO_BASE = 16'(SERVO_MIN_US / TICK_US);
    localparam logic [15:0] SERVO_SPAN = 16'((SERVO_MAX_US - SERVO_MIN_US) / TICK_US);
    localparam int FREQ_MAX_HZ = 20000;
    // least half period in ticks, rounded up
    localparam int HALF_MIN_INT = (1000000 + 2 * FREQ_MAX_HZ * TICK_US - 1)
        / (2 * FREQ_MAX_HZ * TICK_US);
    localparam logic [15:0] HALF_MIN = 16'(HALF_MIN_INT);

    // ==========================================================
    // field widths and reset values
    // ==========================================================
    localparam int WIDE_W = 16;
    localparam int NARROW_W = 8;
    localparam int AO_W = 10;
    localparam logic [AO_W-1:0] AO_RESET = 10'h000;
    localparam logic [AO_W-1:0] AO_FULL = 10'h3ff;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_SERVO,
        MODE_DUTY,
        MODE_UNIVERSAL,
        MODE_FREQ
    } pwm_mode_t;

    typedef struct packed {
        pwm_mode_t mode;
        logic [15:0] prescale;
        logic [WIDE_W-1:0] period;
        logic [WIDE_W-1:0] set_a;
        logic [WIDE_W-1:0] set_b;
    } pair_cfg_t;

    typedef struct packed {
        pwm_mode_t mode;
        logic [15:0] prescale;
        logic [NARROW_W-1:0] period;
        logic [NARROW_W-1:0] set_a;
        logic [NARROW_W-1:0] set_b;
    } narrow_cfg_t;

endpackage

// File: pwm_servo_props.sv
`timescale 1ns/1ps

// ==========================================================
// port checker
// ==========================================================
module pwm_servo_props (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // settings and codes
    input pwm_servo_pkg::pair_cfg_t wide_cfg,
    input pwm_servo_pkg::narrow_cfg_t narrow_cfg,
    input wire logic [pwm_servo_pkg::AO_W-1:0] ao_code_0,
    input wire logic ao_wr_0,
    input wire logic [pwm_servo_pkg::AO_W-1:0] ao_code_1,
    input wire logic ao_wr_1,
    // outputs under watch
    input wire logic wide_pair_chan_a,
    input wire logic wide_pair_chan_b,
    input wire logic narrow_pair_chan_a,
    input wire logic narrow_pair_chan_b,
    input wire logic [pwm_servo_pkg::AO_W-1:0] analog_out_chan_0,
    input wire logic [pwm_servo_pkg::AO_W-1:0] analog_out_chan_1
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic wide_idle;
    logic narrow_idle;
    // pair has seen no mode since reset
    always_ff @(posedge ref_clk) begin
        if (srst) wide_idle <= 1'b1;
        else if (wide_cfg.mode != pwm_servo_pkg::MODE_OFF) wide_idle <= 1'b0;
    end
    always_ff @(posedge ref_clk) begin
        if (srst) narrow_idle <= 1'b1;
        else if (narrow_cfg.mode != pwm_servo_pkg::MODE_OFF) narrow_idle <= 1'b0;
    end
    chk_reset_pulses_low: assert property (@(posedge ref_clk) disable iff (1'b0) srst |=>
        {wide_pair_chan_a, wide_pair_chan_b, narrow_pair_chan_a, narrow_pair_chan_b} == 4'h0)
        else $error("pulse output high after reset");
    chk_reset_analog_zero: assert property (@(posedge ref_clk) disable iff (1'b0) srst |=>
        analog_out_chan_0 == 10'h000 && analog_out_chan_1 == 10'h000)
        else $error("analog output not cleared by reset");
    chk_wide_idle_low: assert property (wide_idle |-> !wide_pair_chan_a && !wide_pair_chan_b)
        else $error("wide pair active before a mode was chosen");
    chk_narrow_idle_low: assert property (narrow_idle |-> !(narrow_pair_chan_a | narrow_pair_chan_b))
        else $error("narrow pair active before a mode was chosen");
    chk_ao0_write_lands: assert property (clk_en && ao_wr_0 |=> analog_out_chan_0 == $past(ao_code_0))
        else $error("analog channel 0 missed its code");
    chk_ao1_write_lands: assert property (clk_en && ao_wr_1 |=> analog_out_chan_1 == $past(ao_code_1))
        else $error("analog channel 1 missed its code");
    chk_ao0_code_holds: assert property (!(clk_en && ao_wr_0) |=> $stable(analog_out_chan_0))
        else $error("analog channel 0 changed without a write");
    chk_ao1_code_holds: assert property (!(clk_en && ao_wr_1) |=> $stable(analog_out_chan_1))
        else $error("analog channel 1 changed without a write");
    chk_pulses_frozen: assert property (!clk_en |=> $stable({wide_pair_chan_a, wide_pair_chan_b,
        narrow_pair_chan_a, narrow_pair_chan_b}))
        else $error("pulse output moved while disabled");
    cover property ($rose(wide_pair_chan_b) && wide_cfg.mode == pwm_servo_pkg::MODE_UNIVERSAL);
    cover property ($rose(narrow_pair_chan_a) && narrow_cfg.mode == pwm_servo_pkg::MODE_FREQ);
    cover property (ao_wr_0 && ao_code_0 == pwm_servo_pkg::AO_FULL);
endmodule // pwm_servo_props

bind four_channel_pwm_servo_unit pwm_servo_props pwm_servo_props_i (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .wide_cfg(wide_cfg),
    .narrow_cfg(narrow_cfg), .ao_code_0(ao_code_0), .ao_wr_0(ao_wr_0), .ao_code_1(ao_code_1),
    .ao_wr_1(ao_wr_1), .wide_pair_chan_a(wide_pair_chan_a), .wide_pair_chan_b(wide_pair_chan_b),
    .narrow_pair_chan_a(narrow_pair_chan_a), .narrow_pair_chan_b(narrow_pair_chan_b),
    .analog_out_chan_0(analog_out_chan_0), .analog_out_chan_1(analog_out_chan_1));

// File: pulse_load.sv
`timescale 1ns/1ps

// ==========================================================
// pulse-driven load: measures high time and period in cycles
// ==========================================================
module pulse_load (
    // sampling clock and pulse input
    input wire logic ref_clk,
    input wire logic level,
    // last complete measurements
    output logic [31:0] high_len,
    output logic [31:0] period_len
);
    logic [31:0] hi_cnt;
    logic [31:0] per_cnt;
    logic last;
    // count from rising edge to rising edge, latch high run on fall
    always @(posedge ref_clk) begin
        last <= level;
        if (level && !last) begin
            period_len <= per_cnt;
            per_cnt <= 32'h1;
        end else begin
            per_cnt <= per_cnt + 32'h1;
        end
        if (!level && last) high_len <= hi_cnt;
        hi_cnt <= level ? (last ? hi_cnt + 32'h1 : 32'h1) : 32'h0;
    end
endmodule // pulse_load

// File: testbench.sv
`timescale 1ns/1ps

module testbench;
    typedef struct {
        pwm_servo_pkg::pwm_mode_t wm;
        logic [15:0] wpre, wper, wa, wb;
        pwm_servo_pkg::pwm_mode_t nm;
        logic [7:0] nper, na, nb;
        int wait_cyc;
        logic [31:0] exp[8];
    } row_t;
    logic ref_clk, srst, clk_en, ao_wr_0, ao_wr_1;
    pwm_servo_pkg::pair_cfg_t wide_cfg;
    pwm_servo_pkg::narrow_cfg_t narrow_cfg;
    logic [9:0] ao_code_0, ao_code_1, analog_out_chan_0, analog_out_chan_1;
    logic [3:0] outs;
    logic [31:0] hi[4];
    logic [31:0] per[4];
    int failures = 0;
    int n_checks = 0;
    // duty, universal, frequency: high and period of wa, wb, na, nb
    row_t rows[3] = '{
        '{pwm_servo_pkg::MODE_DUTY, 16'h0001, 16'h0003, 16'h0002, 16'h0001,
          pwm_servo_pkg::MODE_DUTY, 8'hc8, 8'h64, 8'h01, 1000,
          '{32'd4, 32'd8, 32'd2, 32'd8, 32'd100, 32'd201, 32'd1, 32'd201}},
        '{pwm_servo_pkg::MODE_UNIVERSAL, 16'h0000, 16'h0004, 16'h0001, 16'h0007,
          pwm_servo_pkg::MODE_UNIVERSAL, 8'h02, 8'h02, 8'h01, 200,
          '{32'd1, 32'd5, 32'd5, 32'd10, 32'd2, 32'd3, 32'd3, 32'd6}},
        '{pwm_servo_pkg::MODE_FREQ, 16'h0000, 16'h0000, 16'h0019, 16'h0000,
          pwm_servo_pkg::MODE_FREQ, 8'h00, 8'h1e, 8'h1a, 40000,
          '{32'd5000, 32'd10000, 32'd5000, 32'd10000, 32'd6000, 32'd12000, 32'd5200, 32'd10400}}
    };

    four_channel_pwm_servo_unit four_channel_pwm_servo_unit_i (
        .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .wide_cfg(wide_cfg),
        .narrow_cfg(narrow_cfg), .ao_code_0(ao_code_0), .ao_wr_0(ao_wr_0),
        .ao_code_1(ao_code_1), .ao_wr_1(ao_wr_1), .wide_pair_chan_a(outs[0]),
        .wide_pair_chan_b(outs[1]), .narrow_pair_chan_a(outs[2]), .narrow_pair_chan_b(outs[3]),
        .analog_out_chan_0(analog_out_chan_0), .analog_out_chan_1(analog_out_chan_1));

    // one load on each pulse output
    for (genvar g = 0; g < 4; g++) begin : loads
        pulse_load pulse_load_i (.ref_clk(ref_clk), .level(outs[g]), .high_len(hi[g]),
            .period_len(per[g]));
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // clock and watchdog
    // ==========================================================
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        conclude();
    end

    // ==========================================================
    // stimulus
    // ==========================================================
    initial begin
        srst = 1'b1;
        clk_en = 1'b1;
        wide_cfg = '0;
        narrow_cfg = '0;
        {ao_wr_0, ao_wr_1, ao_code_0, ao_code_1} = '0;
        repeat (5) @(posedge ref_clk);
        #1 srst = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1 check("outputs after reset", {28'h0, outs}, 32'h0);
        // table of modes
        foreach (rows[i]) begin
            wide_cfg = '{rows[i].wm, rows[i].wpre, rows[i].wper, rows[i].wa, rows[i].wb};
            narrow_cfg = '{rows[i].nm, 16'h0000, rows[i].nper, rows[i].na, rows[i].nb};
            repeat (rows[i].wait_cyc) @(posedge ref_clk);
            #1;
            for (int c = 0; c < 4; c++) begin
                check($sformatf("row %0d high %0d", i, c), hi[c], rows[i].exp[2*c]);
                check($sformatf("row %0d period %0d", i, c), per[c], rows[i].exp[2*c+1]);
            end
        end
        // analog writes back to back, then a write while frozen
        {ao_wr_0, ao_wr_1, ao_code_0, ao_code_1} = {2'b11, 10'h3ff, 10'h155};
        @(posedge ref_clk);
        #1 {ao_wr_1, ao_code_0} = {1'b0, 10'h000};
        check("analog 0 full", 32'(analog_out_chan_0), 32'h3ff);
        check("analog 1 code", 32'(analog_out_chan_1), 32'h155);
        @(posedge ref_clk);
        #1 {clk_en, ao_code_0} = {1'b0, 10'h2aa};
        check("analog 0 second", 32'(analog_out_chan_0), 32'h000);
        check("analog 1 held", 32'(analog_out_chan_1), 32'h155);
        repeat (3) @(posedge ref_clk);
        #1 {clk_en, ao_wr_0} = 2'b10;
        check("analog 0 frozen", 32'(analog_out_chan_0), 32'h000);
        // reset in mid-run with pairs switched off
        srst = 1'b1;
        wide_cfg = '0;
        narrow_cfg = '0;
        repeat (2) @(posedge ref_clk);
        #1 srst = 1'b0;
        repeat (30) @(posedge ref_clk);
        #1 check("outputs after second reset", {28'h0, outs}, 32'h0);
        check("analog after reset", {12'h0, analog_out_chan_0, analog_out_chan_1}, 32'h0);
        conclude();
    end
endmodule // testbench
